/* File: gexs_top.sv */
module gexs_top
  import gexs_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        sof,
  input  wire logic        eof,
  input  wire logic        rolling_strobe,
  input  wire logic        readout_done,
  input  wire logic        frex_pin_i,
  output logic             frex_pin_o,
  output logic             frex_pin_oe,
  output logic             strobe_o,
  output logic             shutter_o,
  output logic             readout_start,
  output logic             busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [7:0]          regs_r   [GEXS_NREG];
  logic [7:0]          regs_nxt [GEXS_NREG];
  logic [GEXS_NREG-1:0] hit;
  logic [7:0]          rdata_r;
  logic [7:0]          rdata_nxt;
  logic                rvalid_r;
  logic                accept;
  logic                sw_fire;
  logic                req_set;

  // Address decode per register
  for (genvar i = 0; i < GEXS_NREG; i++) begin : g_dec
    assign hit[i] = (reg_addr == GEXS_OFS[i]);
  end

  assign req_set = reg_wr && hit[GEXS_I_CTRL] && reg_wdata[GEXS_B_REQ];

  // Writes, and self-clear of the request; a new request wins
  always_comb begin
    for (int i = 0; i < GEXS_NREG; i++) begin
      regs_nxt[i] = regs_r[i];
      if (reg_wr && hit[i]) begin
        regs_nxt[i] = reg_wdata & GEXS_MASK[i];
      end
    end
    if (accept && sw_fire && !req_set) begin
      regs_nxt[GEXS_I_CTRL][GEXS_B_REQ] = 1'b0;
    end
  end

  // Read data; unmapped addresses read zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      rdata_nxt = 8'h00;
      for (int i = 0; i < GEXS_NREG; i++) begin
        if (hit[i]) begin
          rdata_nxt = regs_r[i];
        end
      end
    end
  end

  // Register storage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < GEXS_NREG; i++) begin
        regs_r[i] <= GEXS_RST[i];
      end
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      for (int i = 0; i < GEXS_NREG; i++) begin
        regs_r[i] <= regs_nxt[i];
      end
      rdata_r  <= rdata_nxt;
      rvalid_r <= reg_rd;
    end
  end

  assign reg_rdata  = rdata_r;
  assign reg_rvalid = rvalid_r;

  ////////////////////////////////////////////////////////////////////////////
  // Live settings and the copy taken at trigger

  gexs_cfg_t cfg;
  gexs_cfg_t shd_r;
  gexs_cfg_t shd_nxt;

  // Field assembly from the register bytes
  always_comb begin
    cfg.exposure = {regs_r[GEXS_I_EXP_H], regs_r[GEXS_I_EXP_M],
                    regs_r[GEXS_I_EXP_L]};
    cfg.strobe_width = {regs_r[GEXS_I_STW_H][3:0], regs_r[GEXS_I_STW_M],
                        regs_r[GEXS_I_STW_L]};
    cfg.shutter_delay = {regs_r[GEXS_I_SHD_H][4:0],
                         regs_r[GEXS_I_SHD_L]};
    cfg.precharge = {regs_r[GEXS_I_PCH_H], regs_r[GEXS_I_PCH_L]};
    cfg.readout_delay = {regs_r[GEXS_I_ROD_H],
                         regs_r[GEXS_I_ROD_L]};
    cfg.strobe_delay = {regs_r[GEXS_I_STD_H][4:0],
                        regs_r[GEXS_I_STD_L]};
    cfg.repeat_eof       = regs_r[GEXS_I_RPT][GEXS_B_RPT_EOF];
    cfg.strobe_frame_sel = regs_r[GEXS_I_CTRL][GEXS_B_STB_SEL];
    cfg.no_precharge     = regs_r[GEXS_I_CTRL][GEXS_B_NOPCHG];
    cfg.strobe_pol       = regs_r[GEXS_I_CTRL][GEXS_B_STB_POL];
    cfg.shutter_pol      = regs_r[GEXS_I_CTRL][GEXS_B_SHUT_POL];
    cfg.pin_trigger      = regs_r[GEXS_I_CTRL][GEXS_B_PIN_TRIG];
    cfg.no_latch         = regs_r[GEXS_I_CTRL][GEXS_B_NOLATCH];
  end

  // Snapshot on each accepted trigger
  always_comb begin
    shd_nxt = shd_r;
    if (accept) begin
      shd_nxt = cfg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger qualification

  logic pin_d_r;
  logic pin_rise;
  logic align_ok;
  gexs_seq_t seq_r;
  gexs_seq_t seq_nxt;

  // Request waits for its frame boundary unless latching is bypassed
  assign align_ok = cfg.no_latch ||
                    (cfg.repeat_eof ? eof : sof);
  assign sw_fire  = !cfg.pin_trigger && regs_r[GEXS_I_CTRL][GEXS_B_REQ]
                    && align_ok;
  assign pin_rise = cfg.pin_trigger && frex_pin_i && !pin_d_r;
  assign accept   = (seq_r == GEXS_SQ_IDLE) && (sw_fire || pin_rise);

  ////////////////////////////////////////////////////////////////////////////
  // Counters

  logic        pchg_exp;
  logic        slow_exp;
  logic        sdly_exp;
  logic        swid_exp;
  logic        pchg_load;
  logic        slow_load;
  logic [23:0] slow_val;
  logic        sdly_load;
  logic        swid_load;

  gexs_timer #(.W(16), .STEP(GEXS_STEP_ONE)) u_pchg (
    .clock   (clock),
    .rst     (rst),
    .load    (pchg_load),
    .value   (cfg.precharge),
    .expired (pchg_exp)
  );

  // Shared by exposure, shutter delay and readout delay (all 128 steps)
  gexs_timer #(.W(24), .STEP(GEXS_STEP_EXPO)) u_slow (
    .clock   (clock),
    .rst     (rst),
    .load    (slow_load),
    .value   (slow_val),
    .expired (slow_exp)
  );

  gexs_timer #(.W(13), .STEP(GEXS_STEP_STD)) u_sdly (
    .clock   (clock),
    .rst     (rst),
    .load    (sdly_load),
    .value   (cfg.strobe_delay),
    .expired (sdly_exp)
  );

  gexs_timer #(.W(20), .STEP(GEXS_STEP_ONE)) u_swid (
    .clock   (clock),
    .rst     (rst),
    .load    (swid_load),
    .value   (shd_r.strobe_width),
    .expired (swid_exp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Exposure sequencer

  logic expo_start;
  logic ro_start_nxt;

  // Phase order and counter loads
  always_comb begin
    seq_nxt      = seq_r;
    pchg_load    = 1'b0;
    slow_load    = 1'b0;
    slow_val     = shd_r.exposure;
    expo_start   = 1'b0;
    ro_start_nxt = 1'b0;
    case (seq_r)
      GEXS_SQ_IDLE: begin
        if (accept) begin
          if (cfg.no_precharge) begin
            seq_nxt    = GEXS_SQ_EXPO;
            slow_load  = 1'b1;
            slow_val   = cfg.exposure;
            expo_start = 1'b1;
          end else begin
            seq_nxt   = GEXS_SQ_PCHG;
            pchg_load = 1'b1;
          end
        end
      end
      GEXS_SQ_PCHG: begin
        if (pchg_exp) begin
          seq_nxt    = GEXS_SQ_EXPO;
          slow_load  = 1'b1;
          slow_val   = shd_r.exposure;
          expo_start = 1'b1;
        end
      end
      GEXS_SQ_EXPO: begin
        if (shd_r.pin_trigger) begin
          if (!frex_pin_i) begin
            seq_nxt      = GEXS_SQ_READ;
            ro_start_nxt = 1'b1;
          end
        end else if (slow_exp) begin
          seq_nxt   = GEXS_SQ_SHUT;
          slow_load = 1'b1;
          slow_val  = {11'h000, shd_r.shutter_delay};
        end
      end
      GEXS_SQ_SHUT: begin
        if (slow_exp) begin
          seq_nxt   = GEXS_SQ_RDLY;
          slow_load = 1'b1;
          slow_val  = {8'h00, shd_r.readout_delay};
        end
      end
      GEXS_SQ_RDLY: begin
        if (slow_exp) begin
          seq_nxt      = GEXS_SQ_READ;
          ro_start_nxt = 1'b1;
        end
      end
      GEXS_SQ_READ: begin
        if (readout_done) begin
          seq_nxt = GEXS_SQ_IDLE;
        end
      end
      default: seq_nxt = GEXS_SQ_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame strobe

  gexs_stb_t stb_r;
  gexs_stb_t stb_nxt;

  // Delay from trigger, or wait for exposure start, then width
  always_comb begin
    stb_nxt   = stb_r;
    sdly_load = 1'b0;
    swid_load = 1'b0;
    case (stb_r)
      GEXS_ST_IDLE: begin
        if (accept) begin
          if (cfg.strobe_delay != 13'h0000) begin
            stb_nxt   = GEXS_ST_DLY;
            sdly_load = 1'b1;
          end else begin
            stb_nxt = GEXS_ST_WAIT;
          end
        end
      end
      GEXS_ST_DLY: begin
        if (sdly_exp) begin
          stb_nxt   = (shd_r.strobe_width != 20'h0_0000) ? GEXS_ST_ON
                                                          : GEXS_ST_IDLE;
          swid_load = 1'b1;
        end
      end
      GEXS_ST_WAIT: begin
        if (expo_start || (seq_r == GEXS_SQ_EXPO)) begin // Skipped precharge
          stb_nxt   = (shd_r.strobe_width != 20'h0_0000) ? GEXS_ST_ON
                                                          : GEXS_ST_IDLE;
          swid_load = 1'b1;
        end
      end
      GEXS_ST_ON: begin
        if (swid_exp) begin
          stb_nxt = GEXS_ST_IDLE;
        end
      end
      default: stb_nxt = GEXS_ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers

  logic ro_start_r;
  logic busy_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      seq_r      <= GEXS_SQ_IDLE;
      stb_r      <= GEXS_ST_IDLE;
      shd_r      <= '0;
      pin_d_r    <= 1'b0;
      ro_start_r <= 1'b0;
      busy_r     <= 1'b0;
    end else begin
      seq_r      <= seq_nxt;
      stb_r      <= stb_nxt;
      shd_r      <= shd_nxt;
      pin_d_r    <= frex_pin_i;
      ro_start_r <= ro_start_nxt;
      busy_r     <= (seq_nxt != GEXS_SQ_IDLE);
    end
  end

  assign readout_start = ro_start_r;
  assign busy          = busy_r;

  ////////////////////////////////////////////////////////////////////////////
  // Pins

  gexs_pins_t pins;
  logic       shut_close;
  logic       frex_level;

  // Shutter closed after its delay, frame signal high through exposure
  assign shut_close = !shd_r.pin_trigger && ((seq_r == GEXS_SQ_RDLY) ||
                      (seq_r == GEXS_SQ_READ));
  assign frex_level = (seq_r == GEXS_SQ_PCHG) || (seq_r == GEXS_SQ_EXPO);

  gexs_pin_drive u_pins (
    .clock            (clock),
    .rst              (rst),
    .frame_strobe     (stb_r == GEXS_ST_ON),
    .rolling_strobe   (rolling_strobe),
    .shutter_close    (shut_close),
    .frex_level       (frex_level),
    .strobe_frame_sel (cfg.strobe_frame_sel),
    .strobe_pol       (cfg.strobe_pol),
    .shutter_pol      (cfg.shutter_pol),
    .pin_trigger      (cfg.pin_trigger),
    .pins             (pins)
  );

  assign strobe_o    = pins.strobe;
  assign shutter_o   = pins.shutter;
  assign frex_pin_o  = pins.frex_o;
  assign frex_pin_oe = pins.frex_oe;

endmodule // gexs_top

/* File: gexs_pkg.sv */
package gexs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam int GEXS_NREG = 16;

  localparam logic [15:0] GEXS_OFS_EXP_H  = 16'h3f85;
  localparam logic [15:0] GEXS_OFS_EXP_M  = 16'h3f86;
  localparam logic [15:0] GEXS_OFS_EXP_L  = 16'h3f87;
  localparam logic [15:0] GEXS_OFS_STW_H  = 16'h3f89;
  localparam logic [15:0] GEXS_OFS_STW_M  = 16'h3f8a;
  localparam logic [15:0] GEXS_OFS_STW_L  = 16'h3f8b;
  localparam logic [15:0] GEXS_OFS_SHD_H  = 16'h3f8c;
  localparam logic [15:0] GEXS_OFS_SHD_L  = 16'h3f8d;
  localparam logic [15:0] GEXS_OFS_PCH_H  = 16'h3f8e;
  localparam logic [15:0] GEXS_OFS_PCH_L  = 16'h3f8f;
  localparam logic [15:0] GEXS_OFS_ROD_H  = 16'h3f90;
  localparam logic [15:0] GEXS_OFS_ROD_L  = 16'h3f91;
  localparam logic [15:0] GEXS_OFS_STD_H  = 16'h3f92;
  localparam logic [15:0] GEXS_OFS_STD_L  = 16'h3f93;
  localparam logic [15:0] GEXS_OFS_RPT    = 16'h3f9e;
  localparam logic [15:0] GEXS_OFS_CTRL   = 16'h3f9f;

  // Register indices, in the order of the tables below
  localparam int GEXS_I_EXP_H = 0;
  localparam int GEXS_I_EXP_M = 1;
  localparam int GEXS_I_EXP_L = 2;
  localparam int GEXS_I_STW_H = 3;
  localparam int GEXS_I_STW_M = 4;
  localparam int GEXS_I_STW_L = 5;
  localparam int GEXS_I_SHD_H = 6;
  localparam int GEXS_I_SHD_L = 7;
  localparam int GEXS_I_PCH_H = 8;
  localparam int GEXS_I_PCH_L = 9;
  localparam int GEXS_I_ROD_H = 10;
  localparam int GEXS_I_ROD_L = 11;
  localparam int GEXS_I_STD_H = 12;
  localparam int GEXS_I_STD_L = 13;
  localparam int GEXS_I_RPT   = 14;
  localparam int GEXS_I_CTRL  = 15;

  localparam logic [15:0] GEXS_OFS [GEXS_NREG] = '{
    GEXS_OFS_EXP_H, GEXS_OFS_EXP_M, GEXS_OFS_EXP_L, GEXS_OFS_STW_H,
    GEXS_OFS_STW_M, GEXS_OFS_STW_L, GEXS_OFS_SHD_H, GEXS_OFS_SHD_L,
    GEXS_OFS_PCH_H, GEXS_OFS_PCH_L, GEXS_OFS_ROD_H, GEXS_OFS_ROD_L,
    GEXS_OFS_STD_H, GEXS_OFS_STD_L, GEXS_OFS_RPT, GEXS_OFS_CTRL};

  // Values after reset
  localparam logic [7:0] GEXS_RST [GEXS_NREG] = '{
    8'h08, 8'h00, 8'h08, 8'h00, 8'h06, 8'h00, 8'h00, 8'h44,
    8'h1f, 8'h40, 8'h00, 8'h01, 8'h00, 8'h00, 8'h01, 8'h04};

  // Implemented bits; the others read as zero
  localparam logic [7:0] GEXS_MASK [GEXS_NREG] = '{
    8'hff, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'h1f, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'h1f, 8'hff, 8'h01, 8'hbf};

  // Control and repeat register bit positions
  localparam int GEXS_B_REQ      = 7;
  localparam int GEXS_B_STB_SEL  = 5;
  localparam int GEXS_B_NOPCHG   = 4;
  localparam int GEXS_B_STB_POL  = 3;
  localparam int GEXS_B_SHUT_POL = 2;
  localparam int GEXS_B_PIN_TRIG = 1;
  localparam int GEXS_B_NOLATCH  = 0;
  localparam int GEXS_B_RPT_EOF  = 0;

  // Counter steps in system clock cycles
  localparam int GEXS_STEP_EXPO = 128;
  localparam int GEXS_STEP_SHUT = 128;
  localparam int GEXS_STEP_ROD  = 128;
  localparam int GEXS_STEP_STD  = 256;
  localparam int GEXS_STEP_ONE  = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    GEXS_SQ_IDLE = 3'b000,
    GEXS_SQ_PCHG = 3'b001,
    GEXS_SQ_EXPO = 3'b010,
    GEXS_SQ_SHUT = 3'b011,
    GEXS_SQ_RDLY = 3'b100,
    GEXS_SQ_READ = 3'b101
  } gexs_seq_t;

  typedef enum logic [1:0] {
    GEXS_ST_IDLE = 2'b00,
    GEXS_ST_DLY  = 2'b01,
    GEXS_ST_WAIT = 2'b10,
    GEXS_ST_ON   = 2'b11
  } gexs_stb_t;

  typedef struct packed {
    logic [23:0] exposure;
    logic [19:0] strobe_width;
    logic [12:0] shutter_delay;
    logic [15:0] precharge;
    logic [15:0] readout_delay;
    logic [12:0] strobe_delay;
    logic        repeat_eof;
    logic        strobe_frame_sel;
    logic        no_precharge;
    logic        strobe_pol;
    logic        shutter_pol;
    logic        pin_trigger;
    logic        no_latch;
  } gexs_cfg_t;

  typedef struct packed {
    logic strobe;
    logic shutter;
    logic frex_o;
    logic frex_oe;
  } gexs_pins_t;

endpackage : gexs_pkg

/* File: gexs_timer.sv */
module gexs_timer
  import gexs_pkg::*;
#(
  parameter int W    = 16,
  parameter int STEP = 1
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  output logic              expired
);

  localparam int PW = (STEP > 1) ? $clog2(STEP) : 1;
  localparam logic [PW-1:0] PRE_TOP = PW'(STEP - 1);

  if (W < 1 || STEP < 1) begin : g_chk
    $error("gexs_timer: W and STEP must be at least 1");
  end

  logic [W-1:0]  cnt_r;
  logic [W-1:0]  cnt_nxt;
  logic [PW-1:0] pre_r;
  logic [PW-1:0] pre_nxt;

  // Down count of value*STEP cycles after the load
  always_comb begin
    cnt_nxt = cnt_r;
    pre_nxt = pre_r;
    if (load) begin
      cnt_nxt = value;
      pre_nxt = '0;
    end else if (pre_r != '0) begin
      pre_nxt = pre_r - PW'(1);
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - W'(1);
      pre_nxt = PRE_TOP;
    end
  end

  // Registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      pre_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      pre_r <= pre_nxt;
    end
  end

  assign expired = (cnt_r == '0) && (pre_r == '0);

endmodule // gexs_timer

/* File: gexs_pin_drive.sv */
module gexs_pin_drive
  import gexs_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       frame_strobe,
  input  wire logic       rolling_strobe,
  input  wire logic       shutter_close,
  input  wire logic       frex_level,
  input  wire logic       strobe_frame_sel,
  input  wire logic       strobe_pol,
  input  wire logic       shutter_pol,
  input  wire logic       pin_trigger,
  output gexs_pins_t      pins
);

  gexs_pins_t pins_r;
  gexs_pins_t pins_nxt;

  // Polarity, routing and pin direction
  always_comb begin
    pins_nxt.strobe  = strobe_frame_sel ? (frame_strobe ^ strobe_pol)
                                        : rolling_strobe;
    pins_nxt.shutter = shutter_close ^ shutter_pol;
    pins_nxt.frex_o  = frex_level & ~pin_trigger;
    pins_nxt.frex_oe = ~pin_trigger;
  end

  // Output flops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pins_r <= '{strobe: 1'b0, shutter: 1'b0, frex_o: 1'b0, frex_oe: 1'b1};
    end else begin
      pins_r <= pins_nxt;
    end
  end

  assign pins = pins_r;

endmodule // gexs_pin_drive

/* File: gexs_top_sva.sv */
module gexs_top_sva (
  input wire logic clock,
  input wire logic rst,
  input wire logic readout_done,
  input wire logic frex_pin_o,
  input wire logic readout_start,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // Readout pulse only inside a running sequence
  property p_start_busy;
    readout_start |-> busy;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("readout start while idle");
  property p_start_pulse;
    readout_start |=> !readout_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("readout start longer than one cycle");
  property p_read_hold;
    readout_start |=> busy;
  endproperty
  a_read_hold: assert property (p_read_hold)
    else $error("sequence ended at readout start");
  // Readout only after exposure has ended
  property p_start_exp;
    readout_start |-> !frex_pin_o;
  endproperty
  a_start_exp: assert property (p_start_exp)
    else $error("readout start during exposure");
  property p_exp_gap;
    $fell(frex_pin_o) |-> !readout_start;
  endproperty
  a_exp_gap: assert property (p_exp_gap)
    else $error("readout start without delay");
  // Sequence framing
  property p_busy_end;
    $fell(busy) |-> $past(readout_done);
  endproperty
  a_busy_end: assert property (p_busy_end)
    else $error("busy fell without readout done");
  property p_frex_busy;
    frex_pin_o |-> busy;
  endproperty
  a_frex_busy: assert property (p_frex_busy)
    else $error("exposure pin high while idle");
  property p_busy_min;
    $rose(busy) |-> busy [*2];
  endproperty
  a_busy_min: assert property (p_busy_min)
    else $error("sequence too short");
endmodule // gexs_top_sva

/* File: gexs_host_model.sv */
module gexs_host_model (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic frame_en,
  input  wire logic pin_req,
  input  wire logic slow,
  input  wire logic readout_start,
  input  wire logic frex_pin_o,
  input  wire logic frex_pin_oe,
  output logic      sof,
  output logic      eof,
  output logic      rolling_strobe,
  output logic      readout_done,
  output logic      frex_pin_i
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [5:0] cnt_r;
  logic [4:0] rd_r;

  // Frame pulses while frames run
  assign sof = frame_en && cnt_r == 6'h00;
  assign eof = frame_en && cnt_r == 6'h28;
  // Host drives the pin only when the device releases it
  assign frex_pin_i = frex_pin_oe ? frex_pin_o : pin_req;

  // Frame counter, rolling strobe, readout completion
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_r <= 6'h00;
      rd_r <= 5'h00;
      rolling_strobe <= 1'b0;
      readout_done <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 6'h01;
      if (cnt_r == 6'h3f) rolling_strobe <= ~rolling_strobe;
      readout_done <= rd_r == 5'h01;
      if (readout_start) rd_r <= slow ? 5'h14 : 5'h02;
      else if (rd_r != 5'h00) rd_r <= rd_r - 5'h01;
    end
  end
endmodule // gexs_host_model

/* File: testbench.sv */
module testbench;
  import gexs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {
    logic [15:0] a;
    logic [7:0]  r;
    logic [7:0]  w;
  } gexs_row_t;

  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata, rv;
  logic        reg_rvalid, sof, eof, rolling_strobe, readout_done;
  logic        frex_pin_i, frex_pin_o, frex_pin_oe, strobe_o, shutter_o;
  logic        readout_start, busy, busy_q, stb_q, sh_q, fx_q, rs_q;
  logic        frame_en = 1'b0;
  logic        pin_req = 1'b0;
  logic        slow = 1'b0;
  int          bad_count = 0;
  int          check_count = 0;
  int          t = 0;
  int          n_frex = 0;
  int          n_stb = 0;
  int          t_busy, t_stb, t_sh, t_ff, t_rs, t_sof, t_eof;
  gexs_row_t   rows [17];

  always #25 clock = ~clock;

  gexs_top dut (.clock, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .sof, .eof, .rolling_strobe, .readout_done,
    .frex_pin_i, .frex_pin_o, .frex_pin_oe, .strobe_o, .shutter_o,
    .readout_start, .busy);
  gexs_host_model host (.clock, .rst, .frame_en, .pin_req, .slow,
    .readout_start, .frex_pin_o, .frex_pin_oe, .sof, .eof,
    .rolling_strobe, .readout_done, .frex_pin_i);

  // Edge timestamps and active-cycle counts
  always @(posedge clock) begin
    t <= t + 1;
    {busy_q, stb_q, sh_q, fx_q} <= {busy, strobe_o, shutter_o, frex_pin_o};
    rs_q <= rolling_strobe;
    if (frex_pin_o) n_frex <= n_frex + 1;
    if (strobe_o) n_stb <= n_stb + 1;
    if (busy && !busy_q) t_busy <= t;
    if (strobe_o && !stb_q) t_stb <= t;
    if (shutter_o && !sh_q) t_sh <= t;
    if (!frex_pin_o && fx_q) t_ff <= t;
    if (readout_start) t_rs <= t;
    if (sof) t_sof <= t;
    if (eof) t_eof <= t;
    if (t == 20000) begin
      bad_count++;
      $display("ERROR timeout expected end seen hang");
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rng(string n, int lo, int hi, int g);
    check_count++;
    if (g < lo || g > hi) begin
      bad_count++;
      $display("ERROR %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask

  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(negedge clock);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clock);
    reg_wr = 1'b0;
  endtask

  task automatic rd(logic [15:0] a, output logic [7:0] d);
    @(negedge clock);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clock);
    reg_rd = 1'b0;
    d = reg_rdata;
    chk("rvalid", 8'h01, reg_rvalid);
  endtask

  task automatic wait_busy(logic v, int lim);
    for (int i = 0; i < lim && busy !== v; i++) @(negedge clock);
    chk("busy", v, busy);
  endtask

  // One register-triggered frame with the given counts
  task automatic seq(int p, e, s, r, d, w, n);
    int nf, ns, b, pe, x;
    logic [7:0] v [14] = '{8'h00, 8'h00, 8'(e), 8'h00, 8'h00, 8'(w),
      8'h00, 8'(s), 8'h00, 8'(p), 8'h00, 8'(r), 8'h00, 8'(d)};
    pe = n ? 0 : p;
    for (int i = 0; i < 14; i++) wr(GEXS_OFS[i], v[i]);
    wr(GEXS_OFS_CTRL, 8'h20);
    @(negedge clock);
    nf = n_frex;
    ns = n_stb;
    wr(GEXS_OFS_CTRL, 8'ha1 | 8'(n * 16));
    wait_busy(1'b1, 10);
    wr(GEXS_OFS_EXP_L, 8'h00);
    wait_busy(1'b0, 3000);
    b = d ? d * 256 : pe;
    x = pe + e * 128;
    rng("expose", x, x + 8, n_frex - nf);
    rng("width", w, w + 1, n_stb - ns);
    rng("shut_dly", s * 128, s * 128 + 4, t_sh - t_ff);
    rng("read_dly", r * 128, r * 128 + 4, t_rs - t_sh);
    rng("stb_dly", b - 2, b + 4, t_stb - t_busy);
    chk("oe", 8'h01, frex_pin_oe);
    rd(GEXS_OFS_CTRL, rv);
    chk("ctrl", 8'h21 | 8'(n * 16), rv);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 16; i++)
      rows[i] = '{GEXS_OFS[i], GEXS_RST[i], GEXS_MASK[i]};
    rows[16] = '{16'h3f88, 8'h00, 8'h00};
    repeat (16) @(negedge clock);
    rst = 1'b0;
    // Reset values, then masked write-back
    foreach (rows[i]) begin
      rd(rows[i].a, rv);
      chk("reset_val", rows[i].r, rv);
      if (rows[i].a != GEXS_OFS_CTRL) begin
        wr(rows[i].a, 8'hff);
        rd(rows[i].a, rv);
        chk("masked", rows[i].w, rv);
      end
    end
    $display("test registers done");
    seq(0, 0, 0, 1, 0, 4, 0);
    slow = 1'b1;
    seq(20, 2, 1, 0, 1, 3, 0);
    seq(5, 1, 0, 0, 0, 2, 1);
    $display("test sequence done");
    // Latched request waits for frame start or end
    for (int k = 0; k < 2; k++) begin
      wr(GEXS_OFS_RPT, 8'(k));
      wr(GEXS_OFS_CTRL, 8'ha0);
      repeat (20) @(negedge clock);
      chk("busy", 8'h00, busy);
      frame_en = 1'b1;
      wait_busy(1'b1, 100);
      frame_en = 1'b0;
      @(negedge clock);
      rng("align", 1, 1, t_busy - (k ? t_eof : t_sof));
      wait_busy(1'b0, 3000);
    end
    $display("test latch done");
    // Pin-triggered frame
    wr(GEXS_OFS_CTRL, 8'h22);
    @(negedge clock);
    chk("oe", 8'h00, frex_pin_oe);
    pin_req = 1'b1;
    wait_busy(1'b1, 10);
    repeat (50) @(negedge clock);
    pin_req = 1'b0;
    wait_busy(1'b0, 300);
    $display("test pin done");
    // Output polarity and strobe routing
    wr(GEXS_OFS_CTRL, 8'h0c);
    @(negedge clock);
    chk("shutter", 8'h01, shutter_o);
    chk("rolling", rs_q, strobe_o);
    wr(GEXS_OFS_CTRL, 8'h28);
    @(negedge clock);
    chk("strobe", 8'h01, strobe_o);
    chk("shutter", 8'h00, shutter_o);
    $display("test polarity done");
    // Reset in mid-sequence
    wr(GEXS_OFS_CTRL, 8'ha1);
    wait_busy(1'b1, 10);
    rst = 1'b1;
    @(negedge clock);
    chk("busy", 8'h00, busy);
    rst = 1'b0;
    rd(GEXS_OFS_CTRL, rv);
    chk("ctrl", 8'h04, rv);
    chk("shutter", 8'h01, shutter_o);
    $display("test reset done");
    report_and_stop();
  end
endmodule // testbench

bind gexs_top gexs_top_sva u_sva (.clock, .rst, .readout_done,
  .frex_pin_o, .readout_start, .busy);
